/* File: common/spr_pkg.sv */
/*
  Shared constants for the serial-to-parallel receiver: timing derived from the
  system clock, frame layout, register offsets, field positions and reset values.
  Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package spr_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SPR_CLK_HZ = 250_000_000;
  localparam int SPR_MAX_RATE_BPS = 24_000;
  // Shortest legal bit time in clock cycles, rounded up.
  localparam int SPR_MIN_BIT_CYC = (SPR_CLK_HZ + SPR_MAX_RATE_BPS - 1) / SPR_MAX_RATE_BPS;

  localparam int SPR_CNT_W = 20;
  localparam logic [19:0] SPR_CNT_ONE = 20'h00001;
  // Longest period kept so that one and a half periods still fit the counter.
  localparam logic [19:0] SPR_PERIOD_MAX = 20'haaaa0;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int SPR_ADDR_W = 3;
  localparam int SPR_NIB_W = 4;
  localparam int SPR_BYTE_W = 8;
  localparam int SPR_SHIFT_W = 8;
  localparam logic [2:0] SPR_LAST_BIT = 3'h7;
  localparam int SPR_DATA_LSB = 3;
  localparam int SPR_STOP_POS = 7;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  localparam int SPR_AXI_AW = 12;
  localparam logic [11:0] SPR_OFF_CTRL = 12'h000;
  localparam logic [11:0] SPR_OFF_STATUS = 12'h004;
  localparam logic [11:0] SPR_OFF_LATCH = 12'h008;

  localparam int SPR_CTRL_TYPE_BIT = 0;
  localparam int SPR_CTRL_DIS_BIT = 1;
  localparam int SPR_CTRL_RUN_BIT = 2;
  localparam int SPR_CTRL_ADDR_LSB = 4;
  localparam logic SPR_CTRL_TYPE_RST = 1'h0;
  localparam logic SPR_CTRL_DIS_RST = 1'h1;
  localparam logic SPR_CTRL_RUN_RST = 1'h1;
  localparam logic [2:0] SPR_CTRL_ADDR_RST = 3'h0;

  localparam int SPR_ST_BUSY_BIT = 0;
  localparam int SPR_ST_PEND_BIT = 1;
  localparam int SPR_ST_DISC_BIT = 2;
  localparam int SPR_ST_FERR_BIT = 3;

  localparam logic [1:0] SPR_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPR_RESP_SLVERR = 2'h2;

endpackage

/* File: design/spr_frame_rx.sv */
/*
  Frame receiver: times the low first start bit of every frame, derives the bit
  period from that measurement and samples address, data and stop bits.
  Assumes serial_in is synchronous to aclk and idles high.
*/
`timescale 1ns/1ps

module spr_frame_rx
  import spr_pkg::*;
#(
  parameter int MIN_BIT_CYC = SPR_MIN_BIT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic serial_in,
  output logic frame_ok,
  output logic frame_err,
  output logic [2:0] frame_addr,
  output logic [3:0] frame_data,
  output logic busy
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_BREAK} spr_rx_state_t;

  spr_rx_state_t st_r, st_nxt;
  logic line_r, line_nxt;
  logic [19:0] cnt_r, cnt_nxt;
  logic [19:0] period_r, period_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic ok_r, ok_nxt;
  logic err_r, err_nxt;

  // ----------------------------------------------------------------------
  // Start measurement and bit sampling
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    line_nxt = serial_in;
    cnt_nxt = cnt_r;
    period_nxt = period_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    ok_nxt = 1'b0;
    err_nxt = 1'b0;
    unique case (st_r)
      RX_IDLE:
      begin
        if (line_r && !serial_in)
        begin
          st_nxt = RX_START;
          cnt_nxt = SPR_CNT_ONE;
        end
      end
      RX_START:
      begin
        // The low first start bit is timed until the high second one begins.
        if (serial_in)
        begin
          if (cnt_r < SPR_CNT_W'(MIN_BIT_CYC / 2))
            st_nxt = RX_IDLE;
          else
          begin
            st_nxt = RX_BITS;
            period_nxt = cnt_r;
            cnt_nxt = cnt_r + (cnt_r >> 1);
            bit_nxt = '0;
          end
        end
        else if (cnt_r >= SPR_PERIOD_MAX)
          st_nxt = RX_BREAK;
        else
          cnt_nxt = cnt_r + SPR_CNT_ONE;
      end
      RX_BITS:
      begin
        if (cnt_r <= SPR_CNT_ONE)
        begin
          // Address, data and stop arrive least significant bit first.
          shift_nxt = {serial_in, shift_r[SPR_SHIFT_W-1:1]};
          cnt_nxt = period_r;
          bit_nxt = bit_r + 3'h1;
          if (bit_r == SPR_LAST_BIT)
          begin
            ok_nxt = serial_in;
            err_nxt = !serial_in;
            st_nxt = serial_in ? RX_IDLE : RX_BREAK;
          end
        end
        else
          cnt_nxt = cnt_r - SPR_CNT_ONE;
      end
      RX_BREAK:
      begin
        if (serial_in)
          st_nxt = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= RX_IDLE;
      line_r <= 1'b1;
      cnt_r <= '0;
      period_r <= '0;
      bit_r <= '0;
      shift_r <= '0;
      ok_r <= 1'b0;
      err_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      line_r <= line_nxt;
      cnt_r <= cnt_nxt;
      period_r <= period_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      ok_r <= ok_nxt;
      err_r <= err_nxt;
    end
  end

  assign frame_ok = ok_r;
  assign frame_err = err_r;
  assign frame_addr = shift_r[SPR_ADDR_W-1:0];
  assign frame_data = shift_r[SPR_DATA_LSB +: SPR_NIB_W];
  assign busy = (st_r != RX_IDLE);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  fall_starts_frame_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_r == RX_IDLE && line_r && !serial_in) |=> (st_r == RX_START && cnt_r == SPR_CNT_ONE))
    else $error("falling edge in idle did not start a frame");

  period_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_r == RX_START && serial_in && cnt_r >= SPR_CNT_W'(MIN_BIT_CYC / 2))
    |=> (st_r == RX_BITS && period_r == $past(cnt_r)))
    else $error("start period not captured on the rising edge");

  stop_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ok_r |-> (shift_r[SPR_STOP_POS] && $past(st_r) == RX_BITS && !err_r))
    else $error("frame accepted without a high stop bit");

endmodule

/* File: design/spr_receiver_top.sv */
/*
  Serial-to-parallel receiver top: pairs frames into bytes, holds the output
  latch, drives the parallel pins and serves an AXI4-Lite register slave.
  Assumes one 250 MHz clock, synchronous active-low reset and a serial line
  that is synchronous to aclk and idles high.
*/
`timescale 1ns/1ps

module spr_receiver_top
  import spr_pkg::*;
#(
  parameter int MIN_BIT_CYC = SPR_MIN_BIT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  output logic [7:0] parallel_outputs,
  output logic [7:0] parallel_oe,
  output logic latch_change_pulse
);

  logic rx_ok;
  logic rx_err;
  logic [2:0] rx_addr;
  logic [3:0] rx_data;
  logic rx_busy;
  logic pair_hit;

  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic type_r, type_nxt, dis_r, dis_nxt, run_r, run_nxt;
  logic [2:0] own_addr_r, own_addr_nxt, first_addr_r, first_addr_nxt;
  logic pending_r, pending_nxt;
  logic [3:0] low_nib_r, low_nib_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic ack_r, ack_nxt, disc_r, disc_nxt, ferr_r, ferr_nxt;
  logic [7:0] pout_r, pout_nxt, poe_r, poe_nxt;

  spr_frame_rx #(
    .MIN_BIT_CYC(MIN_BIT_CYC)
  ) u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .serial_in(serial_in),
    .frame_ok(rx_ok),
    .frame_err(rx_err),
    .frame_addr(rx_addr),
    .frame_data(rx_data),
    .busy(rx_busy)
  );

  assign pair_hit = rx_ok && pending_r && (rx_addr == first_addr_r);

  // ----------------------------------------------------------------------
  // Register slave, frame pairing, latch and pin drive
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic aw_hs;
    logic w_hs;
    logic [11:0] wa;
    logic [31:0] wd;
    logic ws;
    logic wr_ctrl;
    logic wr_stat;
    aw_hs = s_axi_awvalid && awready_r;
    w_hs = s_axi_wvalid && wready_r;
    wa = aw_hs ? s_axi_awaddr : awaddr_r;
    wd = w_hs ? s_axi_wdata : wdata_r;
    ws = w_hs ? s_axi_wstrb[0] : wstrb0_r;
    wr_ctrl = 1'b0;
    wr_stat = 1'b0;
    awaddr_nxt = aw_hs ? s_axi_awaddr : awaddr_r;
    wdata_nxt = w_hs ? s_axi_wdata : wdata_r;
    wstrb0_nxt = w_hs ? s_axi_wstrb[0] : wstrb0_r;
    aw_got_nxt = aw_got_r || aw_hs;
    w_got_nxt = w_got_r || w_hs;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    if (aw_got_nxt && w_got_nxt && !bvalid_r)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = SPR_RESP_OKAY;
      if (wa[11:2] == SPR_OFF_CTRL[11:2])
        wr_ctrl = ws;
      else if (wa[11:2] == SPR_OFF_STATUS[11:2])
        wr_stat = ws;
      else if (wa[11:2] != SPR_OFF_LATCH[11:2])
        bresp_nxt = SPR_RESP_SLVERR;
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;

    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = SPR_RESP_OKAY;
      rdata_nxt = '0;
      if (s_axi_araddr[11:2] == SPR_OFF_CTRL[11:2])
      begin
        rdata_nxt[SPR_CTRL_TYPE_BIT] = type_r;
        rdata_nxt[SPR_CTRL_DIS_BIT] = dis_r;
        rdata_nxt[SPR_CTRL_RUN_BIT] = run_r;
        rdata_nxt[SPR_CTRL_ADDR_LSB +: SPR_ADDR_W] = own_addr_r;
      end
      else if (s_axi_araddr[11:2] == SPR_OFF_STATUS[11:2])
      begin
        rdata_nxt[SPR_ST_BUSY_BIT] = rx_busy;
        rdata_nxt[SPR_ST_PEND_BIT] = pending_r;
        rdata_nxt[SPR_ST_DISC_BIT] = disc_r;
        rdata_nxt[SPR_ST_FERR_BIT] = ferr_r;
      end
      else if (s_axi_araddr[11:2] == SPR_OFF_LATCH[11:2])
        rdata_nxt[SPR_BYTE_W-1:0] = latch_r;
      else
        rresp_nxt = SPR_RESP_SLVERR;
    end
    arready_nxt = !rvalid_nxt;

    type_nxt = wr_ctrl ? wd[SPR_CTRL_TYPE_BIT] : type_r;
    dis_nxt = wr_ctrl ? wd[SPR_CTRL_DIS_BIT] : dis_r;
    run_nxt = wr_ctrl ? wd[SPR_CTRL_RUN_BIT] : run_r;
    own_addr_nxt = wr_ctrl ? wd[SPR_CTRL_ADDR_LSB +: SPR_ADDR_W] : own_addr_r;

    // Sticky flags: a write of one clears, a new event in the same cycle wins.
    disc_nxt = (disc_r && !(wr_stat && wd[SPR_ST_DISC_BIT]));
    ferr_nxt = (ferr_r && !(wr_stat && wd[SPR_ST_FERR_BIT])) || rx_err;

    pending_nxt = pending_r;
    first_addr_nxt = first_addr_r;
    low_nib_nxt = low_nib_r;
    latch_nxt = latch_r;
    if (rx_err)
      pending_nxt = 1'b0;
    else if (rx_ok && !pending_r)
    begin
      if (rx_addr == own_addr_r)
      begin
        pending_nxt = 1'b1;
        first_addr_nxt = rx_addr;
        low_nib_nxt = rx_data;
      end
    end
    else if (rx_ok)
    begin
      pending_nxt = 1'b0;
      if (pair_hit)
        latch_nxt = {rx_data, low_nib_r};
      else
        disc_nxt = 1'b1;
    end
    if (!run_r)
      latch_nxt = '0;
    ack_nxt = (latch_nxt != latch_r);

    // Open-collector drives low for a one and releases for a zero.
    for (int i = 0; i < SPR_BYTE_W; i++)
    begin
      if (dis_r)
      begin
        pout_nxt[i] = !type_r;
        poe_nxt[i] = 1'b0;
      end
      else if (type_r)
      begin
        pout_nxt[i] = latch_r[i];
        poe_nxt[i] = 1'b1;
      end
      else
      begin
        pout_nxt[i] = !latch_r[i];
        poe_nxt[i] = latch_r[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= SPR_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= SPR_RESP_OKAY;
      type_r <= SPR_CTRL_TYPE_RST;
      dis_r <= SPR_CTRL_DIS_RST;
      run_r <= SPR_CTRL_RUN_RST;
      own_addr_r <= SPR_CTRL_ADDR_RST;
      pending_r <= 1'b0;
      first_addr_r <= '0;
      low_nib_r <= '0;
      latch_r <= '0;
      ack_r <= 1'b0;
      disc_r <= 1'b0;
      ferr_r <= 1'b0;
      pout_r <= '1;
      poe_r <= '0;
    end
    else if (ce)
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      type_r <= type_nxt;
      dis_r <= dis_nxt;
      run_r <= run_nxt;
      own_addr_r <= own_addr_nxt;
      pending_r <= pending_nxt;
      first_addr_r <= first_addr_nxt;
      low_nib_r <= low_nib_nxt;
      latch_r <= latch_nxt;
      ack_r <= ack_nxt;
      disc_r <= disc_nxt;
      ferr_r <= ferr_nxt;
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign parallel_outputs = pout_r;
  assign parallel_oe = poe_r;
  assign latch_change_pulse = ack_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  ack_tracks_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ce) |-> (ack_r == $changed(latch_r)))
    else $error("acknowledge pulse does not match a latch change");

  latch_only_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(ce) && $past(run_r) && $changed(latch_r)) |-> $past(pair_hit))
    else $error("latch changed without a matched frame pair");

  byte_assembly_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && run_r && pair_hit) |=> (latch_r == {$past(rx_data), $past(low_nib_r)}))
    else $error("byte not assembled low nibble first");

  addr_mismatch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rx_ok && pending_r && rx_addr != first_addr_r)
    |=> (!pending_r && disc_r && (!run_r || latch_r == $past(latch_r))))
    else $error("mismatched second frame was not discarded");

  own_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rx_ok && !pending_r && rx_addr != own_addr_r) |=> !pending_r)
    else $error("frame for another address was accepted");

  latch_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !run_r) |=> (latch_r == '0))
    else $error("latch reset did not clear the latch");

  open_collector_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !type_r && !dis_r)
    |=> (poe_r == $past(latch_r) && pout_r == ~$past(latch_r)))
    else $error("open-collector outputs do not invert the latch");

  push_pull_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && type_r && !dis_r) |=> (poe_r == '1 && pout_r == $past(latch_r)))
    else $error("push-pull outputs do not follow the latch");

  out_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && dis_r) |=> (poe_r == '0 && pout_r == {SPR_BYTE_W{!$past(type_r)}}))
    else $error("disabled outputs are still driven");

endmodule

/* File: tb/spr_sender.sv */
/*
  Serial sender model standing at the far end of the receiver's data line.
  Assumes the bench calls send from a process that runs on aclk.
*/
`timescale 1ns/1ps

module spr_sender
(
  input wire logic aclk,
  output logic line
);
  initial line = 1'b1;

  // Sends one frame; every bit lasts t cycles and the line rests high afterwards.
  task automatic send(input logic [2:0] a, input logic [3:0] d, input int t, input logic stp);
    logic [9:0] bits;
    bits = {stp, d, a, 2'b10};
    for (int i = 0; i < 10; i++)
    begin
      repeat (t) @(posedge aclk) line <= bits[i];
    end
    if (!stp)
    begin
      repeat (t) @(posedge aclk) line <= 1'b1;
    end
  endtask
endmodule

/* File: tb/serial_to_parallel_receiver_tb.sv */
/*
  Self-checking bench for the serial-to-parallel receiver top.
  Assumes the register map and timing of the shared package, and a small
  MIN_BIT_CYC so that bit periods of 16 cycles and more are legal.
*/
`timescale 1ns/1ps

module serial_to_parallel_receiver_tb;
  import spr_pkg::*;
  localparam int MINB = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, pulse, ser;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pins, oe;
  logic disc = 1'b0;
  logic ferr = 1'b0;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int exp_latch = 0;
  int pulses = 0;
  int exp_pulses = 0;
  int typ = 0;
  int dis = 1;
  int run = 1;
  int own = 5;

  spr_receiver_top #(.MIN_BIT_CYC(MINB)) spr_receiver_top_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in(ser), .parallel_outputs(pins), .parallel_oe(oe), .latch_change_pulse(pulse));

  spr_sender spr_sender_inst (.aclk(aclk), .line(ser));

  initial forever #2 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    if (pulse === 1'b1) pulses++;
    if (cyc == 40000)
    begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic set_ctrl();
    wr(SPR_OFF_CTRL, {25'h0, own[2:0], 1'b0, run[0], dis[0], typ[0]}, SPR_RESP_OKAY);
  endtask

  // Compares the pins, the acknowledge count and the latch register with the model.
  task automatic pin_chk();
    logic [7:0] l;
    l = exp_latch[7:0];
    repeat (3) @(posedge aclk);
    chk({24'h0, pins}, typ ? (dis ? 32'h0 : {24'h0, l}) : (dis ? 32'hff : {24'h0, ~l}));
    chk({24'h0, oe}, dis ? 32'h0 : (typ ? 32'hff : {24'h0, l}));
    chk(pulses, exp_pulses);
    rchk(SPR_OFF_LATCH, {24'h0, l}, SPR_RESP_OKAY);
    rchk(SPR_OFF_STATUS, {28'h0, ferr, disc, 2'b00}, SPR_RESP_OKAY);
  endtask

  // Sends two frames, the second at a different bit period, and updates the model.
  task automatic pair(input logic [2:0] a1, input logic [2:0] a2, input logic [7:0] b, input int t);
    spr_sender_inst.send(a1, b[3:0], t, 1'b1);
    spr_sender_inst.send(a2, b[7:4], t + 3, 1'b1);
    if (a1 == own[2:0] && a2 == own[2:0])
    begin
      if (exp_latch != b) exp_pulses++;
      exp_latch = b;
    end
    else if (a1 == own[2:0]) disc = 1'b1;
    pin_chk();
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(61346));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    pin_chk();
    rchk(SPR_OFF_CTRL, 32'h6, SPR_RESP_OKAY);
    rchk(12'h00c, 32'h0, SPR_RESP_SLVERR);
    wr(12'h010, 32'h1, SPR_RESP_SLVERR);
    $display("test reset done");
    dis = 0;
    set_ctrl();
    pair(own[2:0], own[2:0], 8'h81, 16);
    for (int i = 0; i < 4; i++) pair(own[2:0], own[2:0], 8'($urandom), 16 + $urandom % 25);
    $display("test open-collector bytes done");
    pair(own[2:0], 3'h3, 8'h5a, 20);
    pair(3'h2, 3'h2, 8'h33, 24);
    spr_sender_inst.send(own[2:0], 4'ha, 18, 1'b0);
    ferr = 1'b1;
    pin_chk();
    wr(SPR_OFF_STATUS, 32'hc, SPR_RESP_OKAY);
    ferr = 1'b0;
    disc = 1'b0;
    pair(own[2:0], own[2:0], 8'hc6, 30);
    $display("test refused frames done");
    for (int m = 0; m < 4; m++)
    begin
      typ = m % 2;
      dis = m / 2;
      set_ctrl();
      pin_chk();
    end
    typ = 1;
    dis = 0;
    set_ctrl();
    pair(own[2:0], own[2:0], 8'($urandom), 40);
    $display("test output modes done");
    run = 0;
    set_ctrl();
    if (exp_latch != 0) exp_pulses++;
    exp_latch = 0;
    pin_chk();
    $display("test latch clear done");
    run = 1;
    set_ctrl();
    pair(own[2:0], own[2:0], 8'h3c, 20);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    typ = 0;
    dis = 1;
    own = 0;
    exp_latch = 0;
    repeat (2) @(posedge aclk);
    pin_chk();
    rchk(SPR_OFF_CTRL, 32'h6, SPR_RESP_OKAY);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
